/* File: shared/pmi_pkg.sv */
// shared constants and types for the phy-side media independent interface
package pmi_pkg;

  // ****************************************
  // clock rates and divider
  // ****************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int MII_100_HZ = 25_000_000;
  localparam int MII_10_HZ = 2_500_000;
  localparam logic [7:0] DIV_HALF_100 = 8'(CLK_HZ / (2 * MII_100_HZ));
  localparam logic [7:0] DIV_HALF_10 = 8'(CLK_HZ / (2 * MII_10_HZ));

  // ****************************************
  // widths and buffer shape
  // ****************************************
  localparam int NIB_W = 4;
  localparam int ADDR_W = 5;
  localparam int REG_W = 16;
  localparam int STAT_W = REG_W + ADDR_W;
  localparam int RXB_W = NIB_W + 1;
  localparam int RXB_DEPTH = 2;

  // ****************************************
  // management frame
  // ****************************************
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0C;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [ADDR_W-1:0] STATUS_REG_ADDR = 5'h11;
  localparam logic [ADDR_W-1:0] ISO_PHY_ADDR = 5'h00;

  // ****************************************
  // consolidated status word layout
  // ****************************************
  localparam int ST_LINK = 0;
  localparam int ST_SPEED = 1;
  localparam int ST_DUPLEX = 2;
  localparam int ST_MODE_LO = 3;
  localparam int ST_RX_ACT = 5;
  localparam int ST_TX_ACT = 6;
  localparam int ST_COL = 7;
  localparam int ST_ISO = 8;
  localparam logic [REG_W-1:0] STATUS_RST = 16'h0000;

  // ****************************************
  // mac interface modes, reported only
  // ****************************************
  localparam logic [1:0] MODE_NIB_10 = 2'h0;
  localparam logic [1:0] MODE_NIB_100 = 2'h1;
  localparam logic [1:0] MODE_SYM_100 = 2'h2;
  localparam logic [1:0] MODE_SER_10 = 2'h3;

  typedef enum logic [3:0] {
    MG_PRE = 4'h1,
    MG_HDR = 4'h2,
    MG_TA = 4'h4,
    MG_DATA = 4'h8
  } pmi_mgmt_state_t;

endpackage : pmi_pkg

/* File: rtl/pmi_fifo.sv */
// small valid/ready buffer for the receive nibble path
`timescale 1ns/1ps
module pmi_fifo import pmi_pkg::*; #(
  parameter int W = RXB_W,
  parameter int DEPTH = RXB_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != CW'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule : pmi_fifo

/* File: rtl/pmi_mgmt.sv */
// two-wire management slave on the station manager's clock
`timescale 1ns/1ps
module pmi_mgmt import pmi_pkg::*; (
  // management clock and system reset
  input wire logic mdc,
  input wire logic srst,
  // status word crossing from the system clock
  input wire logic [STAT_W-1:0] stat_hold,
  input wire logic stat_tog,
  output logic stat_ack,
  // management data pin
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe
);
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic ack_reg;
  logic shadow_ok_reg;
  logic [STAT_W-1:0] shadow_reg;
  pmi_mgmt_state_t state_reg;
  logic [5:0] cnt_reg;
  logic [11:0] hdr_reg;
  logic rd_hit_reg;
  logic [REG_W-1:0] word_reg;
  logic out_reg;
  logic oe_reg;
  logic [1:0] f_op;
  logic [ADDR_W-1:0] f_phy;
  logic [ADDR_W-1:0] f_reg;
  logic f_read;

  assign stat_ack = ack_reg;
  assign mdio_o = out_reg;
  assign mdio_oe = oe_reg;

  // ****************************************
  // reset and status crossing
  // ****************************************
  always_ff @(posedge mdc) begin
    rst_s1_reg <= srst;
    rst_s2_reg <= rst_s1_reg;
    tog_s1_reg <= stat_tog;
    tog_s2_reg <= tog_s1_reg;
  end

  always_ff @(posedge mdc) begin
    if (rst_s2_reg) begin
      ack_reg <= 1'b0;
      shadow_reg <= '0;
      shadow_ok_reg <= 1'b0;
    end else if (tog_s2_reg != ack_reg) begin
      shadow_reg <= stat_hold;
      ack_reg <= tog_s2_reg;
      shadow_ok_reg <= 1'b1;
    end
  end

  // ****************************************
  // frame decode
  // ****************************************
  assign f_op = hdr_reg[10:9];
  assign f_phy = hdr_reg[8:4];
  assign f_reg = {hdr_reg[3:0], mdio_i};
  assign f_read = shadow_ok_reg && hdr_reg[11] && (f_op == OP_READ)
                  && (f_phy == shadow_reg[STAT_W-1:REG_W]);

  // ****************************************
  // frame sequencer
  // ****************************************
  always_ff @(posedge mdc) begin
    if (rst_s2_reg) begin
      state_reg <= MG_PRE;
      cnt_reg <= '0;
      hdr_reg <= '0;
      rd_hit_reg <= 1'b0;
      word_reg <= STATUS_RST;
      out_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        MG_PRE: begin
          if (mdio_i) begin
            cnt_reg <= (cnt_reg == PREAMBLE_LEN) ? cnt_reg : cnt_reg + 1'b1;
          end else if (cnt_reg == PREAMBLE_LEN) begin
            state_reg <= MG_HDR;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= '0;
          end
        end
        MG_HDR: begin
          hdr_reg <= {hdr_reg[10:0], mdio_i};
          if (cnt_reg == HDR_LAST) begin
            state_reg <= MG_TA;
            cnt_reg <= '0;
            rd_hit_reg <= f_read;
            word_reg <= (f_reg == STATUS_REG_ADDR) ? shadow_reg[REG_W-1:0] : '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        MG_TA: begin
          oe_reg <= rd_hit_reg;
          out_reg <= 1'b0;
          state_reg <= MG_DATA;
        end
        MG_DATA: begin
          if (cnt_reg == DATA_BITS) begin
            oe_reg <= 1'b0;
            out_reg <= 1'b1;
            state_reg <= MG_PRE;
            cnt_reg <= '0;
          end else begin
            out_reg <= word_reg[REG_W-1];
            word_reg <= {word_reg[REG_W-2:0], 1'b0};
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= MG_PRE;
        end
      endcase
    end
  end

endmodule : pmi_mgmt

/* File: rtl/pmi_mac_side.sv */
// phy-side media independent interface toward the mac
//
// How it works
// - nibble frames on separate transmit, receive paths
// - runs at 10 or 100 Mbps
// - receive nibble with valid and clock out
// - phy makes both transfer clocks
// - half duplex: carrier on transmit or receive
// - half duplex: collision when both active
// - full duplex: carrier receive only, no collision
// - isolate interface and line pins in reset
// - re-enable outputs once reset completes
// - management clock input, two-way data line
// - management port works in every mode
// - consolidated status register, one read
// - strap address zero keeps interface floated
// - clocks 25 MHz or 2.5 MHz
`timescale 1ns/1ps
module pmi_mac_side import pmi_pkg::*; (
  // system clock and reset
  input wire logic clk,
  input wire logic srst,
  // operating mode
  input wire logic speed_100,
  input wire logic duplex_full,
  input wire logic [1:0] mac_mode,
  input wire logic link_up,
  // address straps
  input wire logic [ADDR_W-1:0] phy_addr_strap,
  // mii transmit
  output logic mii_tx_clk,
  input wire logic [NIB_W-1:0] mii_txd,
  input wire logic mii_tx_en,
  // mii receive
  output logic mii_rx_clk,
  output logic [NIB_W-1:0] mii_rxd,
  output logic mii_rx_dv,
  output logic mii_rx_er,
  // mii media status
  output logic mii_crs,
  output logic mii_col,
  output logic mii_out_oe,
  // management
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // line-side transmit
  output logic [NIB_W-1:0] line_tx_data,
  output logic line_tx_en,
  output logic line_tx_strobe,
  // line-side receive
  input wire logic [NIB_W-1:0] line_rx_data,
  input wire logic line_rx_err,
  input wire logic line_rx_valid,
  output logic line_rx_ready,
  input wire logic line_rx_active,
  // twisted pair drive
  input wire logic tp_drive_pos,
  input wire logic tp_drive_neg,
  output logic twisted_pair_tx_pos,
  output logic twisted_pair_tx_neg,
  output logic twisted_pair_tx_oe
);
  logic [ADDR_W-1:0] strap_s1_reg;
  logic [ADDR_W-1:0] strap_s2_reg;
  logic [ADDR_W-1:0] phy_addr_reg;
  logic iso_reg;
  logic mii_oe_reg;
  logic tp_oe_reg;
  logic tp_pos_reg;
  logic tp_neg_reg;
  logic [7:0] div_cnt_reg;
  logic [7:0] div_half;
  logic xclk_reg;
  logic rise;
  logic [NIB_W:0] tx_s1_reg;
  logic [NIB_W:0] tx_s2_reg;
  logic [NIB_W-1:0] ltx_data_reg;
  logic ltx_en_reg;
  logic ltx_strobe_reg;
  logic [RXB_W-1:0] rxb_data;
  logic rxb_valid;
  logic rxb_pop;
  logic [NIB_W-1:0] rxd_reg;
  logic rx_dv_reg;
  logic rx_er_reg;
  logic rx_act;
  logic tx_act;
  logic crs_reg;
  logic col_reg;
  logic [REG_W-1:0] status_word;
  logic [STAT_W-1:0] stat_hold_reg;
  logic stat_tog_reg;
  logic stat_ack;
  logic ack_s1_reg;
  logic ack_s2_reg;

  // ****************************************
  // reset isolation and address straps
  // ****************************************
  always_ff @(posedge clk) begin
    strap_s1_reg <= phy_addr_strap;
    strap_s2_reg <= strap_s1_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      iso_reg <= 1'b1;
      phy_addr_reg <= ISO_PHY_ADDR;
    end else if (iso_reg) begin
      iso_reg <= 1'b0;
      phy_addr_reg <= strap_s2_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mii_oe_reg <= 1'b0;
      tp_oe_reg <= 1'b0;
    end else begin
      mii_oe_reg <= !iso_reg && (phy_addr_reg != ISO_PHY_ADDR);
      tp_oe_reg <= !iso_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tp_pos_reg <= 1'b0;
      tp_neg_reg <= 1'b0;
    end else begin
      tp_pos_reg <= tp_drive_pos;
      tp_neg_reg <= tp_drive_neg;
    end
  end

  assign mii_out_oe = mii_oe_reg;
  assign twisted_pair_tx_oe = tp_oe_reg;
  assign twisted_pair_tx_pos = tp_pos_reg;
  assign twisted_pair_tx_neg = tp_neg_reg;

  // ****************************************
  // transfer clock divider
  // ****************************************
  assign div_half = speed_100 ? DIV_HALF_100 : DIV_HALF_10;
  assign rise = (div_cnt_reg >= div_half - 8'h01) && !xclk_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt_reg <= 8'h00;
      xclk_reg <= 1'b0;
    end else if (div_cnt_reg >= div_half - 8'h01) begin
      div_cnt_reg <= 8'h00;
      xclk_reg <= !xclk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  assign mii_tx_clk = xclk_reg;
  assign mii_rx_clk = xclk_reg;

  // ****************************************
  // transmit path
  // ****************************************
  always_ff @(posedge clk) begin
    tx_s1_reg <= {mii_tx_en, mii_txd};
    tx_s2_reg <= tx_s1_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ltx_data_reg <= '0;
      ltx_en_reg <= 1'b0;
      ltx_strobe_reg <= 1'b0;
    end else if (rise) begin
      ltx_en_reg <= tx_s2_reg[NIB_W];
      ltx_data_reg <= tx_s2_reg[NIB_W-1:0];
      ltx_strobe_reg <= tx_s2_reg[NIB_W];
    end else begin
      ltx_strobe_reg <= 1'b0;
    end
  end

  assign line_tx_data = ltx_data_reg;
  assign line_tx_en = ltx_en_reg;
  assign line_tx_strobe = ltx_strobe_reg;
  assign tx_act = ltx_en_reg;

  // ****************************************
  // receive path
  // ****************************************
  pmi_fifo #(
    .W(RXB_W),
    .DEPTH(RXB_DEPTH)
  ) u_rx_buf (
    .clk(clk),
    .srst(srst),
    .in_data({line_rx_err, line_rx_data}),
    .in_valid(line_rx_valid),
    .in_ready(line_rx_ready),
    .out_data(rxb_data),
    .out_valid(rxb_valid),
    .out_ready(rxb_pop)
  );

  // one nibble leaves per transfer clock
  assign rxb_pop = rise && !iso_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      rxd_reg <= '0;
      rx_dv_reg <= 1'b0;
      rx_er_reg <= 1'b0;
    end else if (rxb_pop) begin
      rx_dv_reg <= rxb_valid;
      rxd_reg <= rxb_valid ? rxb_data[NIB_W-1:0] : '0;
      rx_er_reg <= rxb_valid && rxb_data[NIB_W];
    end
  end

  assign mii_rxd = rxd_reg;
  assign mii_rx_dv = rx_dv_reg;
  assign mii_rx_er = rx_er_reg;
  assign rx_act = line_rx_active || rx_dv_reg;

  // ****************************************
  // carrier sense and collision
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      crs_reg <= 1'b0;
      col_reg <= 1'b0;
    end else if (duplex_full) begin
      crs_reg <= rx_act;
      col_reg <= 1'b0;
    end else begin
      crs_reg <= rx_act || tx_act;
      col_reg <= rx_act && tx_act;
    end
  end

  assign mii_crs = crs_reg;
  assign mii_col = col_reg;

  // ****************************************
  // consolidated status and crossing
  // ****************************************
  always_comb begin
    status_word = STATUS_RST;
    status_word[ST_LINK] = link_up;
    status_word[ST_SPEED] = speed_100;
    status_word[ST_DUPLEX] = duplex_full;
    status_word[ST_MODE_LO +: 2] = mac_mode;
    status_word[ST_RX_ACT] = rx_act;
    status_word[ST_TX_ACT] = tx_act;
    status_word[ST_COL] = col_reg;
    status_word[ST_ISO] = !mii_oe_reg;
  end

  always_ff @(posedge clk) begin
    ack_s1_reg <= stat_ack;
    ack_s2_reg <= ack_s1_reg;
  end

  // hold stays put while a transfer is pending
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_hold_reg <= '0;
      stat_tog_reg <= 1'b0;
    end else if ((stat_tog_reg == ack_s2_reg)
                 && (stat_hold_reg != {phy_addr_reg, status_word})) begin
      stat_hold_reg <= {phy_addr_reg, status_word};
      stat_tog_reg <= !stat_tog_reg;
    end
  end

  // ****************************************
  // management port, independent of mac mode
  // ****************************************
  pmi_mgmt u_mgmt (
    .mdc(mdc),
    .srst(srst),
    .stat_hold(stat_hold_reg),
    .stat_tog(stat_tog_reg),
    .stat_ack(stat_ack),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe)
  );

endmodule : pmi_mac_side

/* File: tb/pmi_mac_model.sv */
// mac and station manager model facing the phy-side mii block
`timescale 1ns/1ps
module pmi_mac_model (
  // system clock and phy-made transfer clock
  input wire logic clk,
  input wire logic mii_tx_clk,
  // mac transmit
  output logic [3:0] mii_txd,
  output logic mii_tx_en,
  // station manager
  output logic mdc,
  output logic sta_oe,
  output logic sta_o,
  input wire logic mdio
);
  logic [3:0] frame_q[$];
  logic seen_clk = 1'b0;

  initial begin
    mii_txd = 4'h0;
    mii_tx_en = 1'b0;
    mdc = 1'b0;
    sta_oe = 1'b0;
    sta_o = 1'b1;
  end

  // ****************************************
  // transmit: one nibble per phy clock
  // ****************************************
  always @(negedge clk) begin
    if (mii_tx_clk && !seen_clk) begin
      mii_tx_en <= frame_q.size() > 0;
      mii_txd <= frame_q.size() > 0 ? frame_q.pop_front() : ~mii_txd;
    end
    seen_clk <= mii_tx_clk;
  end

  // ****************************************
  // management: clock stands still between frames
  // ****************************************
  task automatic mdc_bit(input logic drive, input logic val, output logic smp);
    mdc = 1'b0;
    sta_oe = drive;
    sta_o = val;
    #32;
    smp = mdio;
    mdc = 1'b1;
    #32;
  endtask : mdc_bit

  task automatic mgmt_read(input logic [4:0] phy, input logic [4:0] ra,
      output logic ta, output logic [15:0] data);
    logic [13:0] hdr;
    logic s;
    hdr = {4'h6, phy, ra};
    for (int i = 0; i < 32; i++) mdc_bit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) mdc_bit(1'b1, hdr[i], s);
    for (int k = 0; k < 19; k++) begin
      mdc_bit(1'b0, 1'b1, s);
      if (k == 1) ta = s;
      if (k >= 2 && k <= 17) data[17-k] = s;
    end
  endtask : mgmt_read
endmodule : pmi_mac_model

/* File: tb/pmi_mac_side_checker.sv */
// port-level assertions for the phy-side mii block
`timescale 1ns/1ps
module pmi_mac_side_checker import pmi_pkg::*; (
  // clock, reset and mode
  input wire logic clk,
  input wire logic srst,
  input wire logic speed_100,
  input wire logic duplex_full,
  input wire logic [ADDR_W-1:0] phy_addr_strap,
  // mii and line side
  input wire logic mii_tx_clk,
  input wire logic mii_rx_clk,
  input wire logic mii_rx_dv,
  input wire logic mii_crs,
  input wire logic mii_col,
  input wire logic mii_out_oe,
  input wire logic line_tx_en,
  input wire logic line_tx_strobe,
  input wire logic line_rx_active,
  input wire logic twisted_pair_tx_oe
);
  default clocking cb @(posedge clk); endclocking
  logic rx_act;
  assign rx_act = line_rx_active | mii_rx_dv;

  property p_crs_half;
    disable iff (srst) !$past(srst) && !$past(duplex_full) |->
      mii_crs == $past(rx_act | line_tx_en);
  endproperty
  a_crs_half: assert property (p_crs_half) else $error("carrier wrong in half duplex");
  property p_col_half;
    disable iff (srst) !$past(srst) && !$past(duplex_full) |->
      mii_col == $past(rx_act & line_tx_en);
  endproperty
  a_col_half: assert property (p_col_half) else $error("collision wrong in half duplex");
  property p_full;
    disable iff (srst) !$past(srst) && $past(duplex_full) |->
      mii_crs == $past(rx_act) && !mii_col;
  endproperty
  a_full: assert property (p_full) else $error("carrier or collision wrong in full duplex");
  property p_iso;
    srst |=> !mii_out_oe && !twisted_pair_tx_oe;
  endproperty
  a_iso: assert property (p_iso) else $error("outputs enabled during reset");
  property p_reen;
    disable iff (srst) $fell(srst) |->
      ##3 twisted_pair_tx_oe && mii_out_oe == (phy_addr_strap != 5'h00);
  endproperty
  a_reen: assert property (p_reen) else $error("enables wrong after reset");
  property p_clk_same;
    disable iff (srst) mii_tx_clk == mii_rx_clk;
  endproperty
  a_clk_same: assert property (p_clk_same) else $error("transfer clocks differ");
  property p_per_100;
    disable iff (srst) $rose(mii_tx_clk) && speed_100 |=>
      !$rose(mii_tx_clk) [*3] ##1 $rose(mii_tx_clk);
  endproperty
  a_per_100: assert property (p_per_100) else $error("fast clock period wrong");
  property p_per_10;
    disable iff (srst) $rose(mii_tx_clk) && !speed_100 |-> ##40 $rose(mii_tx_clk);
  endproperty
  a_per_10: assert property (p_per_10) else $error("slow clock period wrong");
  property p_strobe;
    disable iff (srst) line_tx_strobe |-> line_tx_en && $rose(mii_tx_clk) ##1 !line_tx_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("transmit strobe off clock");
  property p_dv_rise;
    disable iff (srst) $changed(mii_rx_dv) |-> $rose(mii_rx_clk);
  endproperty
  a_dv_rise: assert property (p_dv_rise) else $error("receive valid off clock");

  c_col: cover property (disable iff (srst) mii_col);
  c_strobe: cover property (disable iff (srst) line_tx_strobe && mii_rx_dv);
  c_iso: cover property (disable iff (srst) $fell(srst) ##4 !mii_out_oe);
endmodule : pmi_mac_side_checker

bind pmi_mac_side pmi_mac_side_checker u_chk (.clk, .srst, .speed_100, .duplex_full,
  .phy_addr_strap, .mii_tx_clk, .mii_rx_clk, .mii_rx_dv, .mii_crs, .mii_col, .mii_out_oe,
  .line_tx_en, .line_tx_strobe, .line_rx_active, .twisted_pair_tx_oe);

/* File: tb/tb.sv */
// self-checking bench for the phy-side mii block
`timescale 1ns/1ps
module tb;
  import pmi_pkg::*;
  logic clk, srst, speed_100, duplex_full, link_up, mii_tx_clk, mii_rx_clk, mii_tx_en;
  logic [1:0] mac_mode;
  logic [4:0] phy_addr_strap;
  logic [3:0] mii_txd, mii_rxd, line_tx_data, line_rx_data;
  logic mii_rx_dv, mii_rx_er, mii_crs, mii_col, mii_out_oe, mdc, mdio_i, mdio_o, mdio_oe;
  logic line_tx_en, line_tx_strobe, line_rx_err, line_rx_valid, line_rx_ready, line_rx_active;
  logic tp_drive_pos, tp_drive_neg, twisted_pair_tx_pos, twisted_pair_tx_neg;
  logic twisted_pair_tx_oe, sta_oe, sta_o, last_clk, dmy, tp_ok;
  logic [1:0] tp_prev;
  logic [4:0] exp_rx[$];
  logic [3:0] exp_tx[$];
  int err_count = 0;
  int check_count = 0;
  int col_hits, refused;

  pmi_mac_side dut (.clk, .srst, .speed_100, .duplex_full, .mac_mode, .link_up,
    .phy_addr_strap, .mii_tx_clk, .mii_txd, .mii_tx_en, .mii_rx_clk, .mii_rxd, .mii_rx_dv,
    .mii_rx_er, .mii_crs, .mii_col, .mii_out_oe, .mdc, .mdio_i, .mdio_o, .mdio_oe,
    .line_tx_data, .line_tx_en, .line_tx_strobe, .line_rx_data, .line_rx_err,
    .line_rx_valid, .line_rx_ready, .line_rx_active, .tp_drive_pos, .tp_drive_neg,
    .twisted_pair_tx_pos, .twisted_pair_tx_neg, .twisted_pair_tx_oe);
  pmi_mac_model mac (.clk, .mii_tx_clk, .mii_txd, .mii_tx_en, .mdc, .sta_oe, .sta_o,
    .mdio(mdio_i));
  // management line with pull-up
  assign mdio_i = (mdio_oe ? mdio_o : 1'b1) & (sta_oe ? sta_o : 1'b1);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic ran_out();
    err_count++;
    $display("mismatch at %0t: wait ran out", $time);
    stop_test();
  endtask : ran_out

  always @(posedge clk) begin
    if (line_tx_strobe) check(16'(line_tx_data),
      exp_tx.size() ? 16'(exp_tx.pop_front()) : 16'hXXXX);
    if (mii_tx_clk && !last_clk && mii_rx_dv) check(16'({mii_rx_er, mii_rxd}),
      exp_rx.size() ? 16'(exp_rx.pop_front()) : 16'hXXXX);
    if (mii_col) col_hits++;
    // line drive is a one-clock copy once out of reset
    if (tp_ok) check(16'({twisted_pair_tx_pos, twisted_pair_tx_neg}), 16'(tp_prev));
    tp_prev <= {tp_drive_pos, tp_drive_neg};
    tp_ok <= !srst;
    last_clk <= mii_tx_clk;
  end

  always @(negedge clk) {tp_drive_pos, tp_drive_neg} <= 2'($urandom());

  // ****************************************
  // stimulus tasks
  // ****************************************
  task automatic do_reset();
    srst = 1'b1;
    fork
      repeat (10) @(negedge clk);
      repeat (3) mac.mdc_bit(1'b0, 1'b1, dmy);
    join
    @(negedge clk);
    srst = 1'b0;
    // management reset only clears on running mdc edges
    repeat (3) mac.mdc_bit(1'b0, 1'b1, dmy);
    @(negedge clk);
  endtask : do_reset

  task automatic traffic(input int n);
    logic [4:0] v;
    col_hits = 0;
    line_rx_active = 1'b1;
    for (int i = 0; i < n; i++) begin
      v = 5'($urandom());
      mac.frame_q.push_back(v[3:0]);
      exp_tx.push_back(v[3:0]);
    end
    for (int i = 0; i < n; i++) begin
      v = 5'($urandom());
      @(negedge clk);
      line_rx_valid = 1'b1;
      {line_rx_err, line_rx_data} = v;
      for (int w = 0; !line_rx_ready; w++) begin
        if (w > 200) ran_out();
        refused++;
        @(negedge clk);
      end
      exp_rx.push_back(v);
    end
    @(negedge clk);
    line_rx_valid = 1'b0;
    line_rx_data = ~line_rx_data;
    for (int w = 0; exp_rx.size() || exp_tx.size(); w++) begin
      if (w > 3000) ran_out();
      @(negedge clk);
    end
    line_rx_active = 1'b0;
    repeat (50) @(negedge clk);
  endtask : traffic

  task automatic mgmt(input logic [4:0] phy, input logic [4:0] ra,
      input logic ta_exp, input logic [15:0] exp);
    logic ta;
    logic [15:0] d;
    mac.mgmt_read(phy, ra, ta, d);
    check(16'(ta), 16'(ta_exp));
    check(d, exp);
  endtask : mgmt

  function automatic logic [15:0] stat_exp(input logic iso);
    return {7'h00, iso, 3'h0, mac_mode, duplex_full, speed_100, link_up};
  endfunction : stat_exp

  initial begin
    void'($urandom(32'h85D782F8));
    {speed_100, duplex_full, mac_mode, link_up, phy_addr_strap} = {4'h8, 1'b1, 5'h01};
    {line_rx_data, line_rx_err, line_rx_valid, line_rx_active, refused} = '0;
    do_reset();
    traffic(8);
    check(16'(col_hits != 0), 16'h0001);
    duplex_full = 1'b1;
    traffic(8);
    check(16'(col_hits), 16'h0000);
    speed_100 = 1'b0;
    refused = 0;
    do_reset();
    traffic(6);
    check(16'(refused != 0), 16'h0001);
    for (int m = 0; m < 4; m++) begin
      mac_mode = 2'(m);
      link_up = 1'(m);
      repeat (20) @(negedge clk);
      mgmt(5'h01, STATUS_REG_ADDR, 1'b0, stat_exp(1'b0));
    end
    mgmt(5'h01, 5'h02, 1'b0, 16'h0000);
    mgmt(5'h1F, STATUS_REG_ADDR, 1'b1, 16'hFFFF);
    phy_addr_strap = 5'h00;
    do_reset();
    repeat (10) @(negedge clk);
    check(16'(mii_out_oe), 16'h0000);
    mgmt(5'h00, STATUS_REG_ADDR, 1'b0, stat_exp(1'b1));
    stop_test();
  end
endmodule : tb
